// >>> rtl/aat_trigger_ctrl.sv
/*
 * auxiliary converter trigger, input sequencing and scaling control.
 * assumes an AHB-Lite master on the same clock; trigger pin is async.
 */
// How it works
// - mode field default 00, trigger ignored
// - mode 01 inhibits measurements while active
// - mode 11 only trigger starts, poll ignored
// - chosen trigger edge starts exactly one set
// - rate field picks 1 to 256 Hz
// - poll write starts one set
// - continuous mode starts sets periodically
// - per-input reference bit, default bandgap
// - internal inputs always use backup supply
// - buffer always on or bandgap-only
// - per-input scale field, default divide four
// - internal supply inputs fixed divide by two
// - poll bit self-clears when set finishes
// - only selected inputs are converted
`timescale 1ns/100ps
module aat_trigger_ctrl #(
   parameter longint P_BASE_CYC = aat_pkg::BASE_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_trigger_pin,
   input wire logic i_gpio_polarity_bit,
   input wire logic i_conv_done,
   output logic o_conv_start,
   output logic [2:0] o_conv_input,
   output logic o_conv_use_bandgap,
   output logic [1:0] o_conv_divider,
   output logic o_bandgap_buffer_on,
   output logic o_busy
);
   import aat_pkg::*;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [15:0] ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2;
   logic [15:0] incfg_ff [NUM_EXT];
   logic [15:0] nxt_incfg [NUM_EXT];
   logic wr_ff, nxt_wr;
   logic [7:0] widx_ff, nxt_widx;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] aidx;
   logic set_done;

   assign aidx = i_haddr[9:2];
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // address phase capture, read data and register writes
   always_comb begin
      nxt_wr = 1'b0;
      nxt_widx = widx_ff;
      nxt_rdata = rdata_ff;
      nxt_ctrl1 = ctrl1_ff;
      nxt_ctrl2 = ctrl2_ff;
      for (int k = 0; k < NUM_EXT; k++) begin
         nxt_incfg[k] = incfg_ff[k];
      end
      if (set_done) begin
         nxt_ctrl1[POLL_BIT] = 1'b0;
      end
      if (wr_ff) begin
         case (widx_ff)
            IDX_CTRL_ONE: nxt_ctrl1 = i_hwdata[15:0];
            IDX_CTRL_TWO: nxt_ctrl2 = i_hwdata[15:0];
            IDX_IN_ONE: nxt_incfg[0] = i_hwdata[15:0];
            IDX_IN_TWO: nxt_incfg[1] = i_hwdata[15:0];
            IDX_IN_THREE: nxt_incfg[2] = i_hwdata[15:0];
            IDX_IN_FOUR: nxt_incfg[3] = i_hwdata[15:0];
            default: nxt_wr = 1'b0;
         endcase
      end
      if (i_hsel && i_hready && i_htrans[1]) begin
         nxt_wr = i_hwrite;
         nxt_widx = aidx;
         case (aidx)
            IDX_CTRL_ONE: nxt_rdata = {16'h0, nxt_ctrl1};
            IDX_CTRL_TWO: nxt_rdata = {16'h0, nxt_ctrl2};
            IDX_IN_ONE: nxt_rdata = {16'h0, nxt_incfg[0]};
            IDX_IN_TWO: nxt_rdata = {16'h0, nxt_incfg[1]};
            IDX_IN_THREE: nxt_rdata = {16'h0, nxt_incfg[2]};
            IDX_IN_FOUR: nxt_rdata = {16'h0, nxt_incfg[3]};
            IDX_STATUS: nxt_rdata = {27'h0, o_busy, 1'b0, o_conv_input};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ff <= 1'b0;
         widx_ff <= 8'h00;
         rdata_ff <= 32'h0;
         ctrl1_ff <= 16'h0000;
         ctrl2_ff <= RST_CTRL_TWO;
         for (int k = 0; k < NUM_EXT; k++) begin
            incfg_ff[k] <= RST_IN_CFG;
         end
      end else begin
         wr_ff <= nxt_wr;
         widx_ff <= nxt_widx;
         rdata_ff <= nxt_rdata;
         ctrl1_ff <= nxt_ctrl1;
         ctrl2_ff <= nxt_ctrl2;
         for (int k = 0; k < NUM_EXT; k++) begin
            incfg_ff[k] <= nxt_incfg[k];
         end
      end
   end

   assign o_hrdata = rdata_ff;

   // ----------------------------------------------------------------
   // trigger pin synchroniser and edge detect
   // ----------------------------------------------------------------
   logic [2:0] pin_ff, nxt_pin;
   logic pin_active, pin_edge;
   logic [1:0] tmode;
   logic enabled;

   assign nxt_pin = {pin_ff[1:0], i_trigger_pin};
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_ff <= 3'h0;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign tmode = ctrl2_ff[MODE_HI:MODE_LO];
   assign enabled = ctrl1_ff[ENA_BIT];
   // active level follows the polarity bit
   assign pin_active = (pin_ff[1] == i_gpio_polarity_bit);
   assign pin_edge = pin_active && (pin_ff[2] != i_gpio_polarity_bit);

   // ----------------------------------------------------------------
   // rate timer
   // ----------------------------------------------------------------
   aat_conv_if tif ();
   assign tif.rate = ctrl2_ff[RATE_HI:RATE_LO];
   assign tif.enable = enabled && ctrl1_ff[CTC_BIT] && (tmode != TMODE_HW);

   aat_rate_timer #(.P_BASE_CYC(P_BASE_CYC)) u_timer (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .bus(tif.tmr)
   );

   // ----------------------------------------------------------------
   // trigger selection and sequencer
   // ----------------------------------------------------------------
   aat_state_t state_ff, nxt_state;
   logic [2:0] idx_ff, nxt_idx;
   logic [NUM_IN-1:0] sel;
   logic poll_pend_ff, nxt_poll_pend;
   logic sw_trig, trig, start_ff, nxt_start;
   logic [2:0] found;
   logic any;

   assign sel = ctrl1_ff[NUM_IN-1:0];

   // a poll write is remembered until the set it starts is over
   assign nxt_poll_pend = (wr_ff && widx_ff == IDX_CTRL_ONE
                           && i_hwdata[POLL_BIT]) ||
                          (poll_pend_ff && !set_done);

   // source of a start: software/timer, or the pin only in mode 11
   always_comb begin
      sw_trig = ctrl1_ff[CTC_BIT] ? tif.tick
                                  : (poll_pend_ff && state_ff == AAT_IDLE);
      case (tmode)
         TMODE_HW: trig = pin_edge;
         TMODE_INHIBIT: trig = sw_trig && !pin_active;
         default: trig = sw_trig;
      endcase
      trig = trig && enabled;
   end

   // first selected input at or after a start index
   function automatic logic [3:0] next_sel(input logic [7:0] s,
                                           input logic [3:0] from);
      logic [3:0] r;
      r = 4'h8;
      for (int k = NUM_IN - 1; k >= 0; k--) begin
         if (s[k] && 4'(k) >= from) begin
            r = 4'(k);
         end
      end
      return r;
   endfunction

   // sequencer: one conversion per selected input, triggers ignored until the set ends
   always_comb begin
      logic [3:0] n;
      n = 4'h8;
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_start = 1'b0;
      set_done = 1'b0;
      case (state_ff)
         AAT_IDLE: begin
            n = next_sel(sel, 4'h0);
            if (trig && !n[3]) begin
               nxt_idx = n[2:0];
               nxt_start = 1'b1;
               nxt_state = AAT_CONV;
            end else if (trig) begin
               set_done = 1'b1;
            end
         end
         AAT_CONV: begin
            if (i_conv_done) begin
               nxt_state = AAT_NEXT;
            end
         end
         AAT_NEXT: begin
            n = next_sel(sel, {1'b0, idx_ff} + 4'h1);
            if (!n[3] && idx_ff != 3'h7) begin
               nxt_idx = n[2:0];
               nxt_start = 1'b1;
               nxt_state = AAT_CONV;
            end else begin
               set_done = 1'b1;
               nxt_state = AAT_IDLE;
            end
         end
         default: nxt_state = AAT_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= AAT_IDLE;
         idx_ff <= 3'h0;
         poll_pend_ff <= 1'b0;
         start_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         poll_pend_ff <= nxt_poll_pend;
         start_ff <= nxt_start;
      end
   end

   // ----------------------------------------------------------------
   // per-input reference, divider and buffer control
   // ----------------------------------------------------------------
   logic use_bg;
   logic [1:0] div;

   always_comb begin
      if (idx_ff < 3'(NUM_EXT)) begin
         use_bg = incfg_ff[idx_ff[1:0]][REF_BIT];
         div = incfg_ff[idx_ff[1:0]][SCALE_HI:SCALE_LO];
      end else begin
         use_bg = 1'b0;
         // temperature sensor has no divider, supplies halve
         div = (idx_ff == 3'h7) ? 2'h1 : 2'h2;
      end
   end

   assign o_conv_start = start_ff;
   assign o_conv_input = idx_ff;
   assign o_conv_use_bandgap = use_bg;
   assign o_conv_divider = div;
   assign o_busy = (state_ff != AAT_IDLE);
   assign o_bandgap_buffer_on = enabled && (ctrl2_ff[RBM_BIT] ||
                                (o_busy && use_bg));
endmodule // aat_trigger_ctrl

// >>> pkg/aat_pkg.sv
/*
 * package for the auxiliary converter trigger and scaling block:
 * register word addresses, field positions, reset values, timing.
 * assumes a 200 MHz system clock and an AHB-Lite register bus.
 */
package aat_pkg;

   // -----------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL_ONE = 8'h90;
   localparam logic [7:0] IDX_CTRL_TWO = 8'h91;
   localparam logic [7:0] IDX_IN_ONE = 8'h98;
   localparam logic [7:0] IDX_IN_TWO = 8'h99;
   localparam logic [7:0] IDX_IN_THREE = 8'h9A;
   localparam logic [7:0] IDX_IN_FOUR = 8'h9B;
   localparam logic [7:0] IDX_STATUS = 8'hA0;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int ENA_BIT = 15;
   localparam int CTC_BIT = 14;
   localparam int POLL_BIT = 13;
   localparam int MODE_HI = 13;
   localparam int MODE_LO = 12;
   localparam int RATE_HI = 10;
   localparam int RATE_LO = 8;
   localparam int RBM_BIT = 1;
   localparam int SCALE_HI = 14;
   localparam int SCALE_LO = 13;
   localparam int REF_BIT = 12;
   localparam int NUM_IN = 8;
   localparam int NUM_EXT = 4;

   // -----------------------------------------------------------------
   // reset values and codes
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_CTRL_TWO = 16'h0002;
   localparam logic [15:0] RST_IN_CFG = 16'h7000;
   localparam logic [1:0] TMODE_OFF = 2'h0;
   localparam logic [1:0] TMODE_INHIBIT = 2'h1;
   localparam logic [1:0] TMODE_HW = 2'h3;
   localparam logic [1:0] SCALE_OFF = 2'h0;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam longint CLK_HZ = 200000000;
   localparam longint BASE_HZ = 1;
   localparam longint BASE_CYC = CLK_HZ / BASE_HZ;
   localparam int CONV_NS = 100;
   localparam int CONV_CYC = (CONV_NS + 4) / 5;

   typedef enum logic [1:0] {AAT_IDLE, AAT_CONV, AAT_NEXT} aat_state_t;

endpackage

// >>> pkg/aat_conv_if.sv
/*
 * interface between the sequencer and the rate timer.
 * assumes one clock domain.
 */
`timescale 1ns/100ps
interface aat_conv_if;
   logic [2:0] rate;
   logic enable;
   logic tick;
   modport seq (output rate, output enable, input tick);
   modport tmr (input rate, input enable, output tick);
endinterface

// >>> rtl/aat_rate_timer.sv
/*
 * continuous-mode rate timer: one-cycle tick at the chosen rate.
 * assumes the sequencer drives rate and enable on the same clock.
 */
`timescale 1ns/100ps
module aat_rate_timer #(
   parameter longint P_BASE_CYC = aat_pkg::BASE_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   aat_conv_if.tmr bus
);
   import aat_pkg::*;

   logic [31:0] cnt_ff, nxt_cnt, limit;
   logic tick_ff, nxt_tick;

   // period per rate code: 1, 4, 8 ... 256 Hz
   always_comb begin
      case (bus.rate)
         3'h0: limit = 32'(P_BASE_CYC);
         default: limit = 32'(P_BASE_CYC >> (32'(bus.rate) + 32'h1));
      endcase
      nxt_tick = 1'b0;
      nxt_cnt = cnt_ff + 32'h1;
      if (!bus.enable) begin
         nxt_cnt = 32'h0;
      end else if (cnt_ff + 32'h1 >= limit) begin
         nxt_cnt = 32'h0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign bus.tick = tick_ff;
endmodule // aat_rate_timer

// >>> tb/aat_trigger_ctrl_properties.sv
/* checker for the trigger block: sequencer and bus outputs.
   bound to aat_trigger_ctrl from the bench top file. */
`timescale 1ns/100ps
module aat_trigger_ctrl_props #(
   parameter longint P_BASE_CYC = 1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_conv_done,
   input wire logic o_conv_start,
   input wire logic [2:0] o_conv_input,
   input wire logic o_conv_use_bandgap,
   input wire logic [1:0] o_conv_divider,
   input wire logic o_bandgap_buffer_on,
   input wire logic o_busy,
   input wire logic o_hreadyout,
   input wire logic o_hresp
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // -----------------------------------------------------------------
   // sequencer steps
   // -----------------------------------------------------------------
   sequence s_done;
      i_conv_done && o_busy;
   endsequence
   sequence s_step;
      ##[1:3] (o_conv_start || !o_busy);
   endsequence
   a_next_input: assert property (s_done |-> s_step)
      else $error("no next input after done");
   a_start_pulse: assert property (o_conv_start |=> !o_conv_start [*2])
      else $error("start pulse too long");
   a_start_busy: assert property (o_conv_start |-> o_busy)
      else $error("start outside a set");
   // internal inputs: fixed reference and divider
   a_int_ref: assert property (o_busy && o_conv_input[2] |-> !o_conv_use_bandgap)
      else $error("internal input on bandgap");
   a_int_div: assert property (o_busy && o_conv_input[2] && !(&o_conv_input[1:0])
      |-> o_conv_divider == 2'h2)
      else $error("supply input not halved");
   a_temp_div: assert property (o_busy && o_conv_input == 3'h7
      |-> o_conv_divider == 2'h1)
      else $error("temperature input scaled");
   a_buf_on: assert property (o_busy && o_conv_use_bandgap |-> o_bandgap_buffer_on)
      else $error("buffer off in bandgap conversion");
   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or error");
endmodule // aat_trigger_ctrl_props

// >>> tb/test_aat_trigger_ctrl.sv
/* self-checking bench for the trigger block.
   the bench plays bus master, trigger pin and converter. */
`timescale 1ns/100ps
module test_aat_trigger_ctrl;
   import aat_pkg::*;
   localparam longint BASE = 4096;
   logic i_clk = 0, i_nrst = 0, i_hsel = 0, i_hwrite = 0;
   logic [31:0] i_haddr = 0, i_hwdata = 0, tmp;
   logic [1:0] i_htrans = 0;
   logic [2:0] i_hsize = 3'h2;
   logic pin = 0, pol = 1, done = 0, hready;
   logic [31:0] hrdata;
   logic hreadyout, hresp, start, bg, buf_on, busy;
   logic [2:0] cin;
   logic [1:0] div;
   int error_cnt = 0, n_tests = 0, cyc = 0, n_start = 0, dly = 0;
   int stamp[$];
   logic [5:0] seen[$];
   assign hready = hreadyout;
   always #2.5 i_clk = ~i_clk;
   aat_trigger_ctrl #(.P_BASE_CYC(BASE)) i_dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
      .i_hwdata(i_hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .i_trigger_pin(pin),
      .i_gpio_polarity_bit(pol), .i_conv_done(done), .o_conv_start(start),
      .o_conv_input(cin), .o_conv_use_bandgap(bg), .o_conv_divider(div),
      .o_bandgap_buffer_on(buf_on), .o_busy(busy));
   // converter model: done three cycles after each start; cycle timeout
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      done <= (dly == 1);
      if (start) begin
         dly <= 3;
         n_start <= n_start + 1;
         seen.push_back({cin, bg, div});
         stamp.push_back(cyc);
      end else if (dly != 0) begin
         dly <= dly - 1;
      end
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         finish_test();
      end
   end
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one single transfer: address phase, then data phase
   task bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= {22'h0, ix, 2'h0};
      i_hwrite <= w;
      do @(posedge i_clk); while (hready !== 1'b1);
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      do @(posedge i_clk); while (hready !== 1'b1);
      tmp = hrdata;
   endtask
   task wr(input logic [7:0] ix, input logic [31:0] d);
      bus(1'b1, ix, d);
   endtask
   task rd(input logic [7:0] ix, input logic [31:0] e, input string nm);
      bus(1'b0, ix, 32'h0);
      chk(nm, e, tmp);
   endtask
   task wait_idle;
      repeat (8) @(posedge i_clk);
      while (busy !== 1'b0) @(posedge i_clk);
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task t_reset;
      rd(IDX_CTRL_TWO, 32'h2, "ctrl2");
      rd(IDX_IN_ONE, 32'h7000, "in1");
      rd(8'h92, 32'h0, "unmapped");
   endtask
   task t_poll;
      wr(IDX_IN_ONE, 32'h2000);
      wr(IDX_CTRL_ONE, 32'hA021);
      wait_idle;
      chk("count", 2, n_start);
      chk("first", {3'h0, 1'h0, 2'h1}, seen[0]);
      chk("second", {3'h5, 1'h0, 2'h2}, seen[1]);
      rd(IDX_CTRL_ONE, 32'h8021, "poll");
      chk("buffer", 1, buf_on);
   endtask
   task t_inhibit;
      pin <= 1'b1;
      wr(IDX_CTRL_TWO, 32'h1002);
      wr(IDX_CTRL_ONE, 32'hA001);
      repeat (40) @(posedge i_clk);
      chk("inhibit", 2, n_start);
      // the held poll runs once the pin goes inactive
      pin <= 1'b0;
      wait_idle;
      chk("released", 3, n_start);
      rd(IDX_CTRL_ONE, 32'h8001, "poll clear");
   endtask
   task t_hw;
      pol <= 1'b0;
      pin <= 1'b1;
      wr(IDX_CTRL_TWO, 32'h3002);
      wr(IDX_CTRL_ONE, 32'hA001);
      repeat (20) @(posedge i_clk);
      chk("poll ignored", 3, n_start);
      pin <= 1'b0;
      wait_idle;
      chk("falling", 4, n_start);
      pin <= 1'b1; // released only after the set
      repeat (20) @(posedge i_clk);
      chk("rising", 4, n_start);
      wr(IDX_CTRL_ONE, 32'h8001);
   endtask
   task t_cont;
      wr(IDX_CTRL_TWO, 32'h0302);
      wr(IDX_CTRL_ONE, 32'hC001);
      while (n_start < 7) @(posedge i_clk);
      wr(IDX_CTRL_ONE, 32'h8001);
      chk("period", 256, stamp[6] - stamp[5]);
      chk("periodic", 256, stamp[5] - stamp[4]);
   endtask
   // buffer only during a bandgap conversion
   task t_buffer;
      wait_idle;
      wr(IDX_CTRL_TWO, 32'h0);
      wr(IDX_IN_ONE, 32'h7000);
      chk("buffer idle", 0, buf_on);
      wr(IDX_CTRL_ONE, 32'hA001);
      while (start !== 1'b1) @(posedge i_clk);
      chk("buffer busy", 1, buf_on);
      wait_idle;
      chk("bandgap", {3'h0, 1'h1, 2'h3}, seen[7]);
      chk("buffer off", 0, buf_on);
   endtask
   task finish_test;
      $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_reset;
      t_poll;
      t_inhibit;
      t_hw;
      t_cont;
      t_buffer;
      finish_test();
   end
endmodule // test_aat_trigger_ctrl
bind aat_trigger_ctrl aat_trigger_ctrl_props #(.P_BASE_CYC(P_BASE_CYC)) i_props (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_conv_done(i_conv_done),
   .o_conv_start(o_conv_start), .o_conv_input(o_conv_input),
   .o_conv_use_bandgap(o_conv_use_bandgap), .o_conv_divider(o_conv_divider),
   .o_bandgap_buffer_on(o_bandgap_buffer_on), .o_busy(o_busy),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));
